// ### hdl/lrc_pkg.sv
package lrc_pkg;

  // register byte offsets
  localparam logic [11:0] LRC_OFS_SENSOR_CTRL = 12'h700;
  localparam logic [11:0] LRC_OFS_LOCK_STAT   = 12'h704;
  localparam logic [11:0] LRC_OFS_IRQ_STAT    = 12'h708;
  localparam logic [11:0] LRC_OFS_IRQ_MASK    = 12'h70c;
  localparam logic [11:0] LRC_OFS_LOCK_CNT    = 12'h710;
  localparam logic [11:0] LRC_OFS_UNLOCK_CNT  = 12'h714;
  localparam logic [11:0] LRC_OFS_HK_CTRL     = 12'h718;

  // field positions
  localparam int LRC_BIT_LOOP_RESET = 12;
  localparam int LRC_BIT_HK_MIRROR  = 3;
  localparam int LRC_IRQ_ACCEPT     = 0;
  localparam int LRC_IRQ_REJECT     = 1;
  localparam int LRC_IRQ_LOCK_LOST  = 2;
  localparam int LRC_IRQ_W          = 3;

  // reset values
  localparam logic [31:0] LRC_SENSOR_CTRL_RST = 32'h0000_0000;
  localparam logic [LRC_IRQ_W-1:0] LRC_IRQ_RST = 3'h0;

  // packet layout, in bytes
  localparam int          LRC_PKT_BYTES   = 14;
  localparam int          LRC_FIXED_BYTES = 10;
  localparam logic [3:0]  LRC_IDX_DATA_HI = 4'ha;
  localparam logic [3:0]  LRC_IDX_DATA_LO = 4'hb;
  localparam logic [3:0]  LRC_IDX_CRC_HI  = 4'hc;
  localparam logic [3:0]  LRC_IDX_CRC_LO  = 4'hd;
  localparam logic [3:0]  LRC_IDX_OVER    = 4'he;

  // fixed header: version, type, flag, process id, category,
  // sequence flags, length, secondary header, type, subtype, pad
  localparam logic [0:9][7:0] LRC_HDR_VAL = {
    8'h1c, 8'h7c, 8'hc0, 8'h00, 8'h00,
    8'h07, 8'h11, 8'hc0, 8'h0a, 8'h00};
  localparam logic [0:9][7:0] LRC_HDR_MASK = {
    8'hff, 8'hff, 8'hf8, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  // error-control checksum
  localparam logic [15:0] LRC_CRC_INIT = 16'hffff;
  localparam logic [15:0] LRC_CRC_POLY = 16'h1021;

  // phase-error window, 12-bit telemetry codes
  localparam int          LRC_PE_W      = 12;
  localparam logic [11:0] LRC_PE_LOW    = 12'h680;
  localparam logic [11:0] LRC_PE_HIGH   = 12'hb80;
  localparam int          LRC_IND_W     = 6;
  localparam int          LRC_CNT_W     = 16;

endpackage

// ### hdl/lrc_sat_counter.sv
`timescale 1ns/1ps
module lrc_sat_counter
  import lrc_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // control
  input  wire logic         inc,
  input  wire logic         clr,
  // result
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          at_max = &cnt_q;

  initial begin
    if (W < 2) $error("lrc_sat_counter: W too small");
  end

  // clear wins over count; saturates at all ones
  assign cnt_d = clr ? '0 : ((inc && !at_max) ? cnt_q + 1'b1 : cnt_q);

  always_ff @(posedge clk) begin
    if (!nrst) cnt_q <= '0;
    else       cnt_q <= cnt_d;
  end

  assign count = cnt_q;

endmodule // lrc_sat_counter

// ### hdl/lrc_pkt_check.sv
`timescale 1ns/1ps
module lrc_pkt_check
  import lrc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // packet byte stream
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_last,
  // verdict
  output logic            done,
  output logic            accept,
  output logic            setting
);

  logic [3:0]  idx_q;
  logic        bad_q;
  logic [15:0] crc_q;
  logic [7:0]  crc_hi_q;
  logic        set_q;
  logic        done_q;
  logic        acc_q;
  logic        setting_q;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ LRC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // per-byte field check
  wire in_fixed = idx_q < 4'(LRC_FIXED_BYTES);
  wire [7:0] exp_val  = in_fixed ? LRC_HDR_VAL[idx_q]  : 8'h00;
  wire [7:0] exp_mask = in_fixed ? LRC_HDR_MASK[idx_q] : 8'h00;
  wire fixed_bad = in_fixed && ((byte_data & exp_mask) != exp_val);
  wire data_bad  = (idx_q == LRC_IDX_DATA_HI && byte_data != 8'h00) ||
                   (idx_q == LRC_IDX_DATA_LO && byte_data[7:1] != 7'h00);
  wire over_bad  = idx_q >= LRC_IDX_OVER;
  wire byte_bad  = fixed_bad || data_bad || over_bad;
  wire in_crc    = idx_q < LRC_IDX_CRC_HI;
  wire crc_ok    = {crc_hi_q, byte_data} == crc_q;
  wire end_ok    = idx_q == LRC_IDX_CRC_LO;
  wire verdict   = !bad_q && !byte_bad && end_ok && crc_ok;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx_q <= 4'h0;
      bad_q <= 1'b0;
      crc_q <= LRC_CRC_INIT;
    end else if (byte_valid && byte_last) begin
      idx_q <= 4'h0;
      bad_q <= 1'b0;
      crc_q <= LRC_CRC_INIT;
    end else if (byte_valid) begin
      idx_q <= over_bad ? idx_q : idx_q + 4'h1;
      bad_q <= bad_q | byte_bad;
      crc_q <= in_crc ? crc_byte(crc_q, byte_data) : crc_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      crc_hi_q <= 8'h00;
      set_q    <= 1'b0;
    end else if (byte_valid) begin
      if (idx_q == LRC_IDX_CRC_HI) crc_hi_q <= byte_data;
      if (idx_q == LRC_IDX_DATA_LO) set_q <= byte_data[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_q    <= 1'b0;
      acc_q     <= 1'b0;
      setting_q <= 1'b0;
    end else begin
      done_q    <= byte_valid && byte_last;
      acc_q     <= byte_valid && byte_last && verdict;
      setting_q <= set_q;
    end
  end

  assign done    = done_q;
  assign accept  = acc_q;
  assign setting = setting_q;

endmodule // lrc_pkt_check

// ### hdl/lrc_loop_reset_decoder.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module lrc_loop_reset_decoder
  import lrc_pkg::*;
#(
  parameter int CNT_W = LRC_CNT_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // telecommand byte stream
  input  wire logic                 tc_valid,
  input  wire logic [7:0]           tc_data,
  input  wire logic                 tc_last,
  // software restart
  input  wire logic                 sw_restart,
  // phase-error telemetry
  input  wire logic                 pe_valid,
  input  wire logic [LRC_PE_W-1:0]  phase_error_telemetry,
  // lock indicator bits
  input  wire logic                 ind_valid,
  input  wire logic [LRC_IND_W-1:0] lock_ind,
  // hardware outputs
  output logic [31:0]               sensor_unit_control,
  output logic                      loop_reset,
  output logic [15:0]               housekeeping_control_word,
  output logic                      lock_alarm,
  output logic [CNT_W-1:0]          lock_ok_count,
  output logic [CNT_W-1:0]          lock_fail_count,
  output logic                      irq
);

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("lrc: CNT_W out of range");
  end

  // ---------------- bus slave ----------------
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_q;

  wire addr_ph  = hsel && hready && htrans[1];
  wire wr_take  = addr_ph && hwrite;
  wire rd_take  = addr_ph && !hwrite;
  wire [11:0] ofs = haddr[11:0];

  wire wr_ctrl   = wr_pend_q && wr_addr_q == LRC_OFS_SENSOR_CTRL;
  wire wr_istat  = wr_pend_q && wr_addr_q == LRC_OFS_IRQ_STAT;
  wire wr_imask  = wr_pend_q && wr_addr_q == LRC_OFS_IRQ_MASK;
  wire wr_lkcnt  = wr_pend_q && wr_addr_q == LRC_OFS_LOCK_CNT;
  wire wr_ulcnt  = wr_pend_q && wr_addr_q == LRC_OFS_UNLOCK_CNT;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= wr_take ? ofs : wr_addr_q;
    end
  end

  // ---------------- command decode ----------------
  logic cmd_done;
  logic cmd_acc;
  logic cmd_set;

  lrc_pkt_check u_check (
    .clk        (clk),
    .nrst       (nrst),
    .byte_valid (tc_valid),
    .byte_data  (tc_data),
    .byte_last  (tc_last),
    .done       (cmd_done),
    .accept     (cmd_acc),
    .setting    (cmd_set)
  );

  wire cmd_rej = cmd_done && !cmd_acc;

  // ---------------- sensor control register ----------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] ctrl_sw;

  assign ctrl_sw = wr_ctrl ? hwdata : ctrl_q;

  always_comb begin
    ctrl_d = ctrl_sw;
    if (cmd_acc) begin
      ctrl_d[LRC_BIT_LOOP_RESET] = cmd_set;
    end
    if (sw_restart) begin
      ctrl_d[LRC_BIT_LOOP_RESET] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) ctrl_q <= LRC_SENSOR_CTRL_RST;
    else       ctrl_q <= ctrl_d;
  end

  assign sensor_unit_control = ctrl_q;
  assign loop_reset = ctrl_q[LRC_BIT_LOOP_RESET];

  // housekeeping mirror
  logic [15:0] hk_q;

  always_ff @(posedge clk) begin
    if (!nrst) hk_q <= 16'h0000;
    else       hk_q <= 16'(ctrl_d[LRC_BIT_LOOP_RESET]) << LRC_BIT_HK_MIRROR;
  end

  assign housekeeping_control_word = hk_q;

  // ---------------- lock judgement ----------------
  logic alarm_q;

  wire pe_in_win = phase_error_telemetry >= LRC_PE_LOW &&
                   phase_error_telemetry <= LRC_PE_HIGH;
  wire lock_lost = pe_valid && !pe_in_win && !alarm_q;

  always_ff @(posedge clk) begin
    if (!nrst)         alarm_q <= 1'b0;
    else if (pe_valid) alarm_q <= !pe_in_win;
  end

  assign lock_alarm = alarm_q;

  wire ind_locked = &lock_ind;

  lrc_sat_counter #(.W(CNT_W)) u_ok_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (ind_valid && ind_locked),
    .clr   (wr_lkcnt),
    .count (lock_ok_count)
  );

  lrc_sat_counter #(.W(CNT_W)) u_fail_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (ind_valid && !ind_locked),
    .clr   (wr_ulcnt),
    .count (lock_fail_count)
  );

  // ---------------- interrupts ----------------
  logic [LRC_IRQ_W-1:0] istat_q;
  logic [LRC_IRQ_W-1:0] imask_q;
  logic [LRC_IRQ_W-1:0] ievt;
  logic [LRC_IRQ_W-1:0] iclr;

  always_comb begin
    ievt = '0;
    ievt[LRC_IRQ_ACCEPT]    = cmd_acc;
    ievt[LRC_IRQ_REJECT]    = cmd_rej;
    ievt[LRC_IRQ_LOCK_LOST] = lock_lost;
  end

  assign iclr = wr_istat ? hwdata[LRC_IRQ_W-1:0] : '0;

  // set wins over clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      istat_q <= LRC_IRQ_RST;
      imask_q <= LRC_IRQ_RST;
    end else begin
      istat_q <= (istat_q & ~iclr) | ievt;
      imask_q <= wr_imask ? hwdata[LRC_IRQ_W-1:0] : imask_q;
    end
  end

  assign irq = |(istat_q & imask_q);

  // ---------------- read path ----------------
  logic [31:0] rd_mux;

  always_comb begin
    case (ofs)
      LRC_OFS_SENSOR_CTRL: rd_mux = ctrl_q;
      LRC_OFS_LOCK_STAT:   rd_mux = {30'h0, alarm_q, loop_reset};
      LRC_OFS_IRQ_STAT:    rd_mux = 32'(istat_q);
      LRC_OFS_IRQ_MASK:    rd_mux = 32'(imask_q);
      LRC_OFS_LOCK_CNT:    rd_mux = 32'(lock_ok_count);
      LRC_OFS_UNLOCK_CNT:  rd_mux = 32'(lock_fail_count);
      LRC_OFS_HK_CTRL:     rd_mux = 32'(hk_q);
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst)        rdata_q <= 32'h0000_0000;
    else if (rd_take) rdata_q <= rd_mux;
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // lrc_loop_reset_decoder

// ### verification/lrc_loop_reset_decoder_asserts.sv
`timescale 1ns/1ps
module lrc_loop_reset_decoder_asserts
  import lrc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // stimulus
  input wire logic                 sw_restart,
  input wire logic                 pe_valid,
  input wire logic [LRC_PE_W-1:0]  phase_error_telemetry,
  input wire logic                 ind_valid,
  input wire logic [LRC_IND_W-1:0] lock_ind,
  // outputs
  input wire logic [31:0]          sensor_unit_control,
  input wire logic                 loop_reset,
  input wire logic [15:0]          housekeeping_control_word,
  input wire logic                 lock_alarm,
  input wire logic [CNT_W-1:0]     lock_ok_count,
  input wire logic [CNT_W-1:0]     lock_fail_count
);
  logic in_win;
  logic all_ok;
  assign in_win = phase_error_telemetry >= LRC_PE_LOW &&
                  phase_error_telemetry <= LRC_PE_HIGH;
  assign all_ok = &lock_ind;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_bit_mirror: assert property (loop_reset == sensor_unit_control[12])
    else $error("loop reset differs from register bit");
  chk_hk_mirror: assert property (
    housekeeping_control_word == {12'h000, loop_reset, 3'h0})
    else $error("housekeeping mirror wrong");
  chk_restart_clear: assert property (sw_restart |=> !loop_reset)
    else $error("restart left loop open");
  chk_alarm_set: assert property (pe_valid && !in_win |=> lock_alarm)
    else $error("alarm not raised");
  chk_alarm_clear: assert property (pe_valid && in_win |=> !lock_alarm)
    else $error("alarm not cleared");
  chk_alarm_hold: assert property (!pe_valid |=> $stable(lock_alarm))
    else $error("alarm changed without sample");
  chk_ok_count: assert property (
    ind_valid && all_ok && !(&lock_ok_count) |=>
    lock_ok_count == $past(lock_ok_count) + 1'b1)
    else $error("lock count not advanced");
  chk_fail_count: assert property (
    ind_valid && !all_ok && !(&lock_fail_count) |=>
    lock_fail_count == $past(lock_fail_count) + 1'b1)
    else $error("unlock count not advanced");
  cover property (sw_restart ##1 !loop_reset);
  cover property (pe_valid && !in_win ##1 lock_alarm);
  cover property ($rose(loop_reset));
endmodule // lrc_loop_reset_decoder_asserts

// ### verification/lrc_tc_source.sv
`timescale 1ns/1ps
module lrc_tc_source (
  // clock
  input wire logic        clk,
  // byte stream
  output logic            tc_valid,
  output logic [7:0]      tc_data,
  output logic            tc_last
);
  logic [10:0] seq_q = 11'h000;
  initial begin
    tc_valid = 1'b0;
    tc_data = 8'h00;
    tc_last = 1'b0;
  end
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    c ^= {d, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  // one packet; bad flips bit 7 of one byte, gap idles between bytes
  task automatic send(input logic [15:0] val, input int bad, input int gap);
    logic [7:0]  b[14];
    logic [15:0] c;
    b = '{8'h1c, 8'h7c, {5'h18, seq_q[10:8]}, seq_q[7:0],
          8'h00, 8'h07, 8'h11, 8'hc0, 8'h0a, 8'h00,
          val[15:8], val[7:0], 8'h00, 8'h00};
    if (bad >= 0 && bad < 12) b[bad] ^= 8'h80;
    c = 16'hffff;
    for (int i = 0; i < 12; i++) c = crc_step(c, b[i]);
    b[12] = c[15:8];
    b[13] = c[7:0];
    if (bad >= 12) b[bad] ^= 8'h80;
    for (int i = 0; i < 14; i++) begin
      if (i > 0 && gap > 0) begin
        tc_valid <= 1'b0;
        tc_data <= ~b[i-1];
        repeat (gap) @(posedge clk);
      end
      tc_valid <= 1'b1;
      tc_data <= b[i];
      tc_last <= (i == 13);
      @(posedge clk);
    end
    tc_valid <= 1'b0;
    tc_last <= 1'b0;
    tc_data <= ~b[13];
    seq_q <= seq_q + 11'h001;
  endtask
endmodule // lrc_tc_source

// ### verification/lrc_loop_reset_decoder_tb_top.sv
`timescale 1ns/1ps
module lrc_loop_reset_decoder_tb_top
  import lrc_pkg::*;
;
  logic        clk, nrst, hsel, hwrite, sw_restart, pe_valid, ind_valid;
  logic        hreadyout, hresp, loop_reset, lock_alarm, irq;
  logic        tc_valid, tc_last;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, suc, r;
  logic [7:0]  tc_data;
  logic [11:0] pe;
  logic [5:0]  ind;
  logic [15:0] hk, ok_cnt, fail_cnt;
  int          miscompares = 0;
  int          num_checks = 0;
  lrc_tc_source src (.clk(clk), .tc_valid(tc_valid), .tc_data(tc_data),
    .tc_last(tc_last));
  lrc_loop_reset_decoder #(.CNT_W(16)) uut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tc_valid(tc_valid), .tc_data(tc_data), .tc_last(tc_last),
    .sw_restart(sw_restart), .pe_valid(pe_valid),
    .phase_error_telemetry(pe), .ind_valid(ind_valid), .lock_ind(ind),
    .sensor_unit_control(suc), .loop_reset(loop_reset),
    .housekeeping_control_word(hk), .lock_alarm(lock_alarm),
    .lock_ok_count(ok_cnt), .lock_fail_count(fail_cnt), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    int n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (++n > 50) begin
        miscompares++;
        close_out();
      end
      @(posedge clk);
    end
  endtask
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask
  task automatic cmd(input logic [15:0] v, input int bad, input int gap);
    src.send(v, bad, gap);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset_vals();
    rd_chk(LRC_OFS_SENSOR_CTRL, LRC_SENSOR_CTRL_RST);
    rd_chk(LRC_OFS_HK_CTRL, 32'h0);
    rd_chk(12'h7fc, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_command();
    ahb(LRC_OFS_SENSOR_CTRL, 1'b1, 32'ha5a5_a5a5);
    ahb(LRC_OFS_IRQ_MASK, 1'b1, 32'h7);
    cmd(16'h0001, -1, 0);
    chk(suc, 32'ha5a5_b5a5);
    chk({16'h0, hk}, 32'h8);
    chk({31'h0, irq}, 32'h1);
    rd_chk(LRC_OFS_IRQ_STAT, 32'h1);
    ahb(LRC_OFS_IRQ_STAT, 1'b1, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    cmd(16'h0001, -1, 0);
    rd_chk(LRC_OFS_SENSOR_CTRL, 32'ha5a5_b5a5);
    cmd(16'h0000, -1, 2);
    chk(suc, 32'ha5a5_a5a5);
    rd_chk(LRC_OFS_LOCK_STAT, 32'h0);
  endtask
  task automatic t_reject();
    int idx[10] = '{0, 1, 2, 5, 6, 7, 8, 9, 10, 12};
    foreach (idx[i]) begin
      cmd(16'h0001, idx[i], 0);
      chk({31'h0, loop_reset}, 32'h0);
    end
    cmd(16'h0002, -1, 0);
    chk({31'h0, loop_reset}, 32'h0);
    rd_chk(LRC_OFS_IRQ_STAT, 32'h3);
    ahb(LRC_OFS_IRQ_STAT, 1'b1, 32'h3);
  endtask
  task automatic t_restart();
    cmd(16'h0001, -1, 0);
    sw_restart <= 1'b1;
    @(posedge clk);
    sw_restart <= 1'b0;
    @(posedge clk);
    chk({31'h0, loop_reset}, 32'h0);
    rd_chk(LRC_OFS_SENSOR_CTRL, 32'ha5a5_a5a5);
  endtask
  task automatic t_lock();
    logic [11:0] code[4] = '{12'h67f, 12'h680, 12'hb80, 12'hb81};
    logic [31:0] exp[4] = '{32'h1, 32'h0, 32'h0, 32'h1};
    ahb(LRC_OFS_IRQ_MASK, 1'b1, 32'h0);
    foreach (code[i]) begin
      pe <= code[i];
      pe_valid <= 1'b1;
      @(posedge clk);
      pe_valid <= 1'b0;
      @(posedge clk);
      chk({31'h0, lock_alarm}, exp[i]);
    end
    chk({31'h0, irq}, 32'h0);
    rd_chk(LRC_OFS_IRQ_STAT, 32'h5);
    ahb(LRC_OFS_IRQ_MASK, 1'b1, 32'h4);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      ind <= (i == 1) ? 6'h3e : 6'h3f;
      ind_valid <= 1'b1;
      @(posedge clk);
    end
    ind_valid <= 1'b0;
    rd_chk(LRC_OFS_LOCK_CNT, 32'h2);
    rd_chk(LRC_OFS_UNLOCK_CNT, 32'h1);
    ahb(LRC_OFS_LOCK_CNT, 1'b1, 32'h0);
    rd_chk(LRC_OFS_LOCK_CNT, 32'h0);
  endtask
  initial begin
    {nrst, hsel, hwrite, sw_restart, pe_valid, ind_valid} = '0;
    htrans = 2'b00;
    haddr = '0;
    hwdata = '0;
    pe = '0;
    ind = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_command();
    t_reject();
    t_restart();
    t_lock();
    close_out();
  end
endmodule // lrc_loop_reset_decoder_tb_top
bind lrc_loop_reset_decoder lrc_loop_reset_decoder_asserts
  #(.CNT_W(CNT_W)) u_chk (
  .clk(clk), .nrst(nrst), .sw_restart(sw_restart), .pe_valid(pe_valid),
  .phase_error_telemetry(phase_error_telemetry), .ind_valid(ind_valid),
  .lock_ind(lock_ind), .sensor_unit_control(sensor_unit_control),
  .loop_reset(loop_reset), .lock_alarm(lock_alarm),
  .housekeeping_control_word(housekeeping_control_word),
  .lock_ok_count(lock_ok_count), .lock_fail_count(lock_fail_count));
